// ==== hvi_pkg.sv ====
// Constants and types shared by the high-voltage indirect register bank
package hvi_pkg;

    // Clock rate, period in nanoseconds
    localparam int CORE_PERIOD_NS = 100;

    // Command codes written to the command register
    localparam logic [7:0] CMD_READ_CFG = 8'h00;
    localparam logic [7:0] CMD_READ_STA = 8'h02;
    localparam logic [7:0] CMD_WRITE_CFG = 8'h08;

    // Data window layout
    localparam int DAT_WIDTH = 12;
    localparam int DAT_TAG_LSB = 8;
    localparam int DAT_TAG_MSB = 11;
    localparam int DAT_BYTE_MSB = 7;

    // Configuration register fields
    localparam int CFG_LIN_EN_BIT = 0;
    localparam int CFG_PASSIVE_BIT = 1;
    localparam int CFG_REENABLE_BIT = 2;
    localparam int CFG_DIAG_BIT = 3;
    localparam int CFG_LVF_EN_BIT = 4;
    localparam logic [7:0] CFG_WRITE_MASK = 8'h1F;
    localparam logic [7:0] CFG_RESET = 8'h00;

    // Status register fields
    localparam int STA_SHORT_BIT = 0;
    localparam int STA_LVF_BIT = 2;
    localparam logic [7:0] STA_RESET = 8'h00;

    // Command register read-back fields
    localparam int CMDR_BUSY_BIT = 0;
    localparam int CMDR_RD_OK_BIT = 1;
    localparam int CMDR_WR_OK_BIT = 2;

    // Data window value after reset
    localparam logic [11:0] DAT_RESET = 12'h000;

    // Short circuit must persist longer than this
    localparam int SHORT_MIN_NS = 20000;
    localparam int SHORT_MIN_CYC = (SHORT_MIN_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;

    // Longest serial transfer latency, rounded down
    localparam int XFER_MAX_NS = 10000;
    localparam int XFER_CYC = (XFER_MAX_NS / CORE_PERIOD_NS) < 1 ? 1 : (XFER_MAX_NS / CORE_PERIOD_NS);

    // Transfer engine states, Gray order
    typedef enum logic [0:0] {
        HVI_IDLE = 1'b0,
        HVI_XFER = 1'b1
    } hvi_state_e;

endpackage : hvi_pkg

// ==== hvi_short_filter.sv ====
// Synchroniser and persistence filter for the LIN short-circuit sense pin
`timescale 1ns/10ps
`default_nettype none
module hvi_short_filter
    import hvi_pkg::*;
#(
    parameter int MIN_CYC = SHORT_MIN_CYC
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Raw sense pin
    input wire logic short_pin,
    // One-cycle detection pulse
    output logic detect_pulse
);

    logic sync1_r; // First synchroniser stage
    logic sync2_r; // Second synchroniser stage
    logic [$clog2(MIN_CYC + 2)-1:0] cnt_r; // Persistence count
    logic fired_r; // Already reported for this episode

    // Two-stage synchroniser
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
        end else begin
            sync1_r <= short_pin;
            sync2_r <= sync1_r;
        end
    end

    // Count while the short persists, fire once past the minimum
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cnt_r <= '0;
            fired_r <= 1'b0;
            detect_pulse <= 1'b0;
        end else begin
            detect_pulse <= 1'b0;
            if (!sync2_r) begin
                cnt_r <= '0;
                fired_r <= 1'b0;
            end else if (!fired_r) begin
                if (cnt_r > ($bits(cnt_r))'(MIN_CYC)) begin
                    detect_pulse <= 1'b1;
                    fired_r <= 1'b1;
                end else begin
                    cnt_r <= cnt_r + 1'b1;
                end
            end
        end
    end

endmodule : hvi_short_filter
`default_nettype wire

// ==== hvi_bank.sv ====
// High-voltage indirect configuration and status bank behind a command/data window
//
// Behaviour
// - Data bits 11:8 report command, read-only
// - Codes: 00 read cfg, 02 status, 08 write
// - Data bits 7:0 carry the register byte
// - Config resets zero, reached only by commands
// - Config bit 4 enables low-voltage flag
// - Config bit 3 switches diagnostic current source
// - Bit 2 re-enables driver, then self-clears
// - Bit 1 set: passive, driver stays on
// - Bit 1 clear: active, driver shut off
// - Short detected only after over 20 us
// - Interrupt reaches core only when enabled
// - Enabled interrupt event copies status into data window
// - Status bit 0 set on short, read-clears
// - Status bit 2 reports supply above threshold
// - Flag changes on drop or re-enable only
// - Busy during automatic copy, within 10 us
`timescale 1ns/10ps
`default_nettype none
module hvi_bank
    import hvi_pkg::*;
#(
    parameter int XFER_CYCLES = XFER_CYC,
    parameter int SHORT_CYCLES = SHORT_MIN_CYC
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Command register port
    input wire logic cmd_wr,
    input wire logic [7:0] cmd_wdata,
    output logic [7:0] cmd_rdata,
    // Data window port
    input wire logic dat_wr,
    input wire logic [11:0] dat_wdata,
    output logic [11:0] dat_rdata,
    // Interrupt enable level and interrupt out
    input wire logic irq_enable,
    output logic hv_irq,
    // High-voltage side sense pins
    input wire logic lin_short_pin,
    input wire logic supply_low_pin,
    // High-voltage side controls
    output logic lin_xcvr_en,
    output logic lin_drv_en,
    output logic atten_diag_en,
    output logic low_voltage_flag_en
);

    // Transfer engine
    hvi_state_e state_r; // Engine state
    logic [$clog2(XFER_CYCLES + 1)-1:0] xfer_cnt_r; // Latency count
    logic [7:0] cur_cmd_r; // Command in flight
    logic auto_r; // Current transfer is an automatic copy
    logic auto_pend_r; // Automatic copy waiting for the engine
    logic rd_ok_r; // Last read completed
    logic wr_ok_r; // Last write completed

    // Register contents
    logic [11:0] hv_data_window_r; // Data window
    logic [7:0] hv_config_r; // Configuration register
    logic sta_short_r; // Status bit 0
    logic lvf_r; // Status bit 2 raw flag
    logic drv_off_r; // Driver shut off by protection
    logic lvf_en_d_r; // Previous flag enable, edge detect

    // Synchronised supply sense
    logic sup_s1_r; // First stage
    logic sup_s2_r; // Second stage

    // Internal events
    logic short_evt; // Short detected this cycle
    logic xfer_done; // Transfer finishes this cycle
    logic start_cmd; // Software command accepted
    logic start_auto; // Automatic copy starts
    logic [7:0] hv_status; // Assembled status byte
    logic cfg_write_now; // Config write lands this cycle
    logic sta_read_now; // Status read lands this cycle

    // Status byte assembly with zero reserved bits
    // Reserved bits 7:3 and 1 stay zero
    // Flag bit masked while the function is off
    function automatic logic [7:0] status_byte(input logic short_b, input logic lvf_b, input logic lvf_en);
        logic [7:0] s;
        s = STA_RESET;
        s[STA_SHORT_BIT] = short_b;
        s[STA_LVF_BIT] = lvf_b & lvf_en;
        return s;
    endfunction : status_byte

    // Data window word: command tag above byte
    // Low nibble of the code names the transfer
    // Every defined code fits in four bits
    function automatic logic [11:0] window_word(input logic [7:0] code, input logic [7:0] byte_v);
        return {code[3:0], byte_v};
    endfunction : window_word

    // Short-circuit persistence filter
    // One detection pulse per episode of the fault
    // Pin must drop before a new episode can fire
    // Glitches below the minimum never reach status
    hvi_short_filter #(
        .MIN_CYC(SHORT_CYCLES)
    ) hvi_short_filter_inst (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .short_pin(lin_short_pin),
        .detect_pulse(short_evt)
    );

    // Supply sense synchroniser
    // Pin is asynchronous to the core clock
    // Only the second stage is read by logic
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            // Both stages report a healthy supply
            sup_s1_r <= 1'b0;
            sup_s2_r <= 1'b0;
        end else begin
            // Shift the pin through both stages
            sup_s1_r <= supply_low_pin;
            sup_s2_r <= sup_s1_r;
        end
    end

    // Event decode
    // Busy includes a pending copy, so a command
    // Never starts while an automatic copy waits
    // Completion strobes exclude the automatic copy
    // So it never writes config or clears status
    always_comb begin
        hv_status = status_byte(sta_short_r, lvf_r, hv_config_r[CFG_LVF_EN_BIT]);
        xfer_done = (state_r == HVI_XFER) && (xfer_cnt_r == '0);
        start_cmd = cmd_wr && (state_r == HVI_IDLE) && !auto_pend_r;
        start_auto = (state_r == HVI_IDLE) && auto_pend_r;
        cfg_write_now = xfer_done && !auto_r && (cur_cmd_r == CMD_WRITE_CFG);
        sta_read_now = xfer_done && !auto_r && (cur_cmd_r == CMD_READ_STA);
    end

    // Pending automatic copy on an enabled interrupt event
    // Held until the engine is free to take it
    // A new event meeting the start keeps it set
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            // No copy owed after reset
            auto_pend_r <= 1'b0;
        end else if (short_evt && irq_enable) begin
            // Enabled interrupt event seen
            auto_pend_r <= 1'b1;
        end else if (start_auto) begin
            // Engine has taken the copy
            auto_pend_r <= 1'b0;
        end
    end

    // Transfer engine: models serial latency to the high-voltage side
    // One transfer at a time with a fixed latency
    // Latency is the worst case of the serial link
    // So software timing never depends on link jitter
    // Counter reloads on every start and counts to zero
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            // Idle, no transfer in flight
            state_r <= HVI_IDLE;
            xfer_cnt_r <= '0;
            cur_cmd_r <= CMD_READ_CFG;
            auto_r <= 1'b0;
        end else begin
            unique case (state_r)
                HVI_IDLE: begin
                    // Automatic copy takes precedence over a new command
                    if (start_auto) begin
                        // Copy status on behalf of the interrupt
                        state_r <= HVI_XFER;
                        xfer_cnt_r <= ($bits(xfer_cnt_r))'(XFER_CYCLES - 1);
                        cur_cmd_r <= CMD_READ_STA;
                        auto_r <= 1'b1;
                    end else if (start_cmd) begin
                        // Software command, code kept as written
                        state_r <= HVI_XFER;
                        xfer_cnt_r <= ($bits(xfer_cnt_r))'(XFER_CYCLES - 1);
                        cur_cmd_r <= cmd_wdata;
                        auto_r <= 1'b0;
                    end
                end
                HVI_XFER: begin
                    // Count down the serial latency
                    if (xfer_done) begin
                        // Last cycle of the transfer
                        state_r <= HVI_IDLE;
                    end else begin
                        // Still in flight
                        xfer_cnt_r <= xfer_cnt_r - 1'b1;
                    end
                end
            endcase
        end
    end

    // Completion flags for the command read-back
    // Valid only while busy is low
    // Cleared at start so a stale success never shows
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            // No command has completed yet
            rd_ok_r <= 1'b0;
            wr_ok_r <= 1'b0;
        end else if (start_cmd || start_auto) begin
            // New transfer hides the old result
            rd_ok_r <= 1'b0;
            wr_ok_r <= 1'b0;
        end else if (xfer_done) begin
            // Reserved codes finish with both flags low
            rd_ok_r <= auto_r || (cur_cmd_r == CMD_READ_CFG) || (cur_cmd_r == CMD_READ_STA);
            wr_ok_r <= !auto_r && (cur_cmd_r == CMD_WRITE_CFG);
        end
    end

    // Data window: software byte, hardware tag
    // Completion beats a software byte write in one cycle
    // The write is then lost; software waits for busy low
    // Tag bits are owned by hardware, never by the bus
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            // Empty window, tag of the read config code
            hv_data_window_r <= DAT_RESET;
        end else if (xfer_done) begin
            // Result or echo of the finished transfer
            unique case (cur_cmd_r)
                CMD_READ_CFG: begin
                    hv_data_window_r <= window_word(CMD_READ_CFG, hv_config_r);
                end
                CMD_READ_STA: begin
                    hv_data_window_r <= window_word(CMD_READ_STA, hv_status);
                end
                CMD_WRITE_CFG: begin
                    hv_data_window_r <= window_word(CMD_WRITE_CFG, hv_data_window_r[7:0]);
                end
                default: begin
                    // Reserved command leaves the window alone
                    hv_data_window_r <= hv_data_window_r;
                end
            endcase
        end else if (dat_wr) begin
            // Only the byte is writable; tag bits ignore writes
            hv_data_window_r[DAT_BYTE_MSB:0] <= dat_wdata[DAT_BYTE_MSB:0];
        end
    end

    // Configuration register, reachable only by the write command
    // Reserved bits are masked before storing
    // Re-enable bit lives one cycle, a strobe for the driver
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            // Everything off after reset
            hv_config_r <= CFG_RESET;
        end else if (cfg_write_now) begin
            // Write lands as the transfer completes
            hv_config_r <= hv_data_window_r[7:0] & CFG_WRITE_MASK;
        end else if (hv_config_r[CFG_REENABLE_BIT]) begin
            // Self-clear after one cycle
            hv_config_r[CFG_REENABLE_BIT] <= 1'b0;
        end
    end

    // Driver shut-off under active protection
    // Passive mode leaves the driver on and only reports
    // A new short beats a re-enable in the same cycle
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            // Driver free after reset
            drv_off_r <= 1'b0;
        end else if (short_evt && !hv_config_r[CFG_PASSIVE_BIT]) begin
            // Short under active protection
            drv_off_r <= 1'b1;
        end else if (hv_config_r[CFG_REENABLE_BIT]) begin
            // Released by the re-enable strobe
            drv_off_r <= 1'b0;
        end
    end

    // Short status bit, detection wins over a read-clear
    // Automatic copy leaves it set, so the interrupt
    // Stays up until software reads status itself
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            // No fault recorded after reset
            sta_short_r <= 1'b0;
        end else if (short_evt) begin
            // Detection first
            sta_short_r <= 1'b1;
        end else if (sta_read_now) begin
            // Cleared by a completed status read
            sta_short_r <= 1'b0;
        end
    end

    // Low-voltage flag: set on enable edge, cleared by supply drop
    // Supply low wins over the enable edge, so a flag
    // Enabled during a drop reads zero
    // Disabled function freezes the raw flag
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            // Flag and edge register start low
            lvf_r <= 1'b0;
            lvf_en_d_r <= 1'b0;
        end else begin
            // Edge register follows the enable every cycle
            lvf_en_d_r <= hv_config_r[CFG_LVF_EN_BIT];
            if (hv_config_r[CFG_LVF_EN_BIT] && sup_s2_r) begin
                // Supply dropped while enabled
                lvf_r <= 1'b0;
            end else if (hv_config_r[CFG_LVF_EN_BIT] && !lvf_en_d_r) begin
                // Fresh enable with a healthy supply
                lvf_r <= 1'b1;
            end
        end
    end

    // Command read-back byte
    // Bits 7:3 read as zero
    // Busy covers the engine and a pending copy
    always_comb begin
        cmd_rdata = 8'h00;
        cmd_rdata[CMDR_BUSY_BIT] = (state_r == HVI_XFER) || auto_pend_r;
        cmd_rdata[CMDR_RD_OK_BIT] = rd_ok_r;
        cmd_rdata[CMDR_WR_OK_BIT] = wr_ok_r;
    end

    // Register-driven outputs
    // Driver needs the transceiver enabled as well
    // Interrupt is the status bit gated by its enable
    always_comb begin
        dat_rdata = hv_data_window_r;
        hv_irq = sta_short_r && irq_enable;
        lin_xcvr_en = hv_config_r[CFG_LIN_EN_BIT];
        lin_drv_en = hv_config_r[CFG_LIN_EN_BIT] && !drv_off_r;
        atten_diag_en = hv_config_r[CFG_DIAG_BIT];
        low_voltage_flag_en = hv_config_r[CFG_LVF_EN_BIT];
    end

endmodule : hvi_bank
`default_nettype wire

// ==== hvi_bank_asserts.sv ====
// Concurrent checks on the ports of the high-voltage indirect bank
`timescale 1ns/10ps
`default_nettype none
module hvi_bank_asserts
    import hvi_pkg::*;
#(
    parameter int XFER_CYCLES = XFER_CYC,
    parameter int SHORT_CYCLES = SHORT_MIN_CYC
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Core side
    input wire logic [7:0] cmd_rdata,
    input wire logic dat_wr,
    input wire logic [11:0] dat_wdata,
    input wire logic [11:0] dat_rdata,
    input wire logic irq_enable,
    input wire logic hv_irq,
    // High-voltage side
    input wire logic lin_short_pin,
    input wire logic lin_xcvr_en,
    input wire logic lin_drv_en,
    input wire logic atten_diag_en,
    input wire logic low_voltage_flag_en
);
    // Longest busy: a command, then a copy it deferred
    localparam int BUSY_MAX = 2 * XFER_CYCLES + 2;
    // Cycles the short pin has stayed high
    logic [7:0] short_run_r;
    // Cycles the busy bit has stayed high
    logic [7:0] busy_run_r;
    // Short pin persistence count, saturating
    always_ff @(posedge core_clk) begin
        if (!rst_n || !lin_short_pin) begin
            short_run_r <= 8'h00;
        end else if (short_run_r != 8'hFF) begin
            short_run_r <= short_run_r + 8'h01;
        end
    end
    // Busy length count, cleared while idle
    always_ff @(posedge core_clk) begin
        if (!rst_n || !cmd_rdata[0]) begin
            busy_run_r <= 8'h00;
        end else if (busy_run_r != 8'hFF) begin
            busy_run_r <= busy_run_r + 8'h01;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    a_tag_read_only: assert property (dat_wr && !cmd_rdata[0] |=> $stable(dat_rdata[11:8]))
        else $error("window tag changed on data write");
    a_byte_written: assert property (dat_wr && !cmd_rdata[0] |=> dat_rdata[7:0] == $past(dat_wdata[7:0]))
        else $error("window byte not taken");
    a_drv_needs_xcvr: assert property (lin_drv_en |-> lin_xcvr_en)
        else $error("driver on with transceiver off");
    a_irq_gated: assert property (hv_irq |-> irq_enable)
        else $error("interrupt while disabled");
    a_busy_length: assert property ($fell(cmd_rdata[0]) |-> busy_run_r >= 8'(XFER_CYCLES - 1))
        else $error("busy too short");
    a_busy_bound: assert property (cmd_rdata[0] |-> ##[1:BUSY_MAX] !cmd_rdata[0])
        else $error("busy stuck");
    a_xcvr_by_cmd: assert property ($changed(lin_xcvr_en) |-> $fell(cmd_rdata[0]))
        else $error("transceiver enable changed outside command");
    a_diag_by_cmd: assert property ($changed(atten_diag_en) |-> $fell(cmd_rdata[0]))
        else $error("diagnostic changed outside command");
    a_lvf_by_cmd: assert property ($changed(low_voltage_flag_en) |-> $fell(cmd_rdata[0]))
        else $error("flag enable changed outside command");
    a_short_persist: assert property ($rose(hv_irq) && $past(irq_enable) |-> $past(short_run_r, 3) >= 8'(SHORT_CYCLES - 1))
        else $error("short detected too early");
endmodule : hvi_bank_asserts
bind hvi_bank hvi_bank_asserts #(.XFER_CYCLES(XFER_CYCLES), .SHORT_CYCLES(SHORT_CYCLES)) hvi_bank_asserts_inst (
    .core_clk(core_clk), .rst_n(rst_n), .cmd_rdata(cmd_rdata), .dat_wr(dat_wr), .dat_wdata(dat_wdata),
    .dat_rdata(dat_rdata), .irq_enable(irq_enable), .hv_irq(hv_irq), .lin_short_pin(lin_short_pin),
    .lin_xcvr_en(lin_xcvr_en), .lin_drv_en(lin_drv_en), .atten_diag_en(atten_diag_en),
    .low_voltage_flag_en(low_voltage_flag_en)
);
`default_nettype wire

// ==== hvi_core_model.sv ====
// Core software model driving the command and data window
`timescale 1ns/10ps
`default_nettype none
module hvi_core_model
    import hvi_pkg::*;
(
    // Clock and busy feedback
    input wire logic core_clk,
    input wire logic busy,
    // Strobes and data towards the bank
    output logic cmd_wr,
    output logic [7:0] cmd_wdata,
    output logic dat_wr,
    output logic [11:0] dat_wdata
);
    // Idle strobes at time zero
    initial begin
        cmd_wr = 1'b0;
        cmd_wdata = 8'h00;
        dat_wr = 1'b0;
        dat_wdata = 12'h000;
    end
    // Bounded poll of busy
    task automatic wait_idle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 40) begin
            @(negedge core_clk);
            n++;
        end
    endtask : wait_idle
    // One-cycle data window write, data garbled after
    task automatic put_dat(input logic [11:0] v);
        dat_wr = 1'b1;
        dat_wdata = v;
        @(negedge core_clk);
        dat_wr = 1'b0;
        dat_wdata = ~v;
    endtask : put_dat
    // Command only when idle, then wait for completion
    task automatic run_cmd(input logic [7:0] c);
        wait_idle();
        cmd_wr = 1'b1;
        cmd_wdata = c;
        @(negedge core_clk);
        cmd_wr = 1'b0;
        cmd_wdata = ~c;
        @(negedge core_clk);
        wait_idle();
    endtask : run_cmd
endmodule : hvi_core_model
`default_nettype wire

// ==== test_hv_indirect_config_status.sv ====
// Self-checking testbench for the high-voltage indirect bank
`timescale 1ns/10ps
`default_nettype none
module test_hv_indirect_config_status
    import hvi_pkg::*;
;
    logic core_clk, rst_n, cmd_wr, dat_wr, irq_enable, hv_irq, lin_short_pin, supply_low_pin;
    logic lin_xcvr_en, lin_drv_en, atten_diag_en, low_voltage_flag_en;
    logic [7:0] cmd_wdata, cmd_rdata;
    logic [11:0] dat_wdata, dat_rdata;
    int err_count = 0;
    int n_tests = 0;
    int cyc = 0;
    hvi_bank #(.XFER_CYCLES(4), .SHORT_CYCLES(6)) hvi_bank_inst (
        .core_clk(core_clk), .rst_n(rst_n), .cmd_wr(cmd_wr), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata),
        .dat_wr(dat_wr), .dat_wdata(dat_wdata), .dat_rdata(dat_rdata), .irq_enable(irq_enable), .hv_irq(hv_irq),
        .lin_short_pin(lin_short_pin), .supply_low_pin(supply_low_pin), .lin_xcvr_en(lin_xcvr_en),
        .lin_drv_en(lin_drv_en), .atten_diag_en(atten_diag_en), .low_voltage_flag_en(low_voltage_flag_en)
    );
    hvi_core_model hvi_core_model_inst (
        .core_clk(core_clk), .busy(cmd_rdata[0]), .cmd_wr(cmd_wr), .cmd_wdata(cmd_wdata),
        .dat_wr(dat_wr), .dat_wdata(dat_wdata)
    );
    // Clock, 100 ns period
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : finish_test
    // Hang guard
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 4000) begin
            err_count++;
            finish_test();
        end
    end
    task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Command, then window and command read-back
    task automatic rdc(input logic [7:0] c, input logic [11:0] ew, input logic [7:0] ec);
        hvi_core_model_inst.run_cmd(c);
        chk("window", ew, dat_rdata);
        chk("cmd_rdata", 12'(ec), 12'(cmd_rdata));
    endtask : rdc
    task automatic wcfg(input logic [7:0] v);
        hvi_core_model_inst.put_dat({4'h0, v});
        rdc(CMD_WRITE_CFG, {4'h8, v}, 8'h04);
    endtask : wcfg
    task automatic t_reset();
        chk("window", 12'h000, dat_rdata);
        rdc(CMD_READ_CFG, 12'h000, 8'h02);
        $display("reset test done");
    endtask : t_reset
    // Every config field, tag bits written as ones
    task automatic t_cfg();
        logic [7:0] vals [3] = '{8'hFF, 8'h19, 8'h0A};
        foreach (vals[i]) begin
            hvi_core_model_inst.put_dat({4'hF, vals[i]});
            rdc(CMD_WRITE_CFG, {4'h8, vals[i]}, 8'h04);
            chk("xcvr", 12'(vals[i][0]), 12'(lin_xcvr_en));
            chk("diag", 12'(vals[i][3]), 12'(atten_diag_en));
            chk("lvf_en", 12'(vals[i][4]), 12'(low_voltage_flag_en));
            rdc(CMD_READ_CFG, {4'h0, vals[i] & 8'h1B}, 8'h02);
        end
        hvi_core_model_inst.put_dat(12'h055);
        rdc(8'h05, 12'h055, 8'h00);
        $display("config test done");
    endtask : t_cfg
    task automatic pulse_short(input int n);
        lin_short_pin = 1'b1;
        repeat (n) @(negedge core_clk);
        lin_short_pin = 1'b0;
        repeat (12) @(negedge core_clk);
    endtask : pulse_short
    task automatic t_short();
        wcfg(8'h01);
        irq_enable = 1'b1;
        pulse_short(4);
        chk("irq", 12'h000, 12'(hv_irq));
        pulse_short(20);
        hvi_core_model_inst.wait_idle();
        chk("irq", 12'h001, 12'(hv_irq));
        chk("drv", 12'h000, 12'(lin_drv_en));
        chk("auto copy", 12'h201, dat_rdata);
        rdc(CMD_READ_STA, 12'h201, 8'h02);
        chk("irq", 12'h000, 12'(hv_irq));
        rdc(CMD_READ_STA, 12'h200, 8'h02);
        wcfg(8'h07);
        @(negedge core_clk);
        chk("drv", 12'h001, 12'(lin_drv_en));
        irq_enable = 1'b0;
        pulse_short(20);
        chk("irq", 12'h000, 12'(hv_irq));
        chk("drv", 12'h001, 12'(lin_drv_en));
        rdc(CMD_READ_STA, 12'h201, 8'h02);
        $display("short test done");
    endtask : t_short
    task automatic t_lvf();
        wcfg(8'h10);
        rdc(CMD_READ_STA, 12'h204, 8'h02);
        supply_low_pin = 1'b1;
        repeat (5) @(negedge core_clk);
        supply_low_pin = 1'b0;
        repeat (3) @(negedge core_clk);
        rdc(CMD_READ_STA, 12'h200, 8'h02);
        wcfg(8'h00);
        rdc(CMD_READ_STA, 12'h200, 8'h02);
        wcfg(8'h10);
        rdc(CMD_READ_STA, 12'h204, 8'h02);
        $display("low voltage test done");
    endtask : t_lvf
    initial begin
        rst_n = 1'b0;
        irq_enable = 1'b0;
        lin_short_pin = 1'b0;
        supply_low_pin = 1'b0;
        repeat (3) @(negedge core_clk);
        rst_n = 1'b1;
        t_reset();
        t_cfg();
        t_short();
        t_lvf();
        finish_test();
    end
endmodule : test_hv_indirect_config_status
`default_nettype wire
